// file: cmp_mode_ctrl.sv
// Mode, privilege, stack selection, exception entry, return and tail-chaining
`timescale 1ns/100ps
`default_nettype none
`include "cmp_map.svh"
module cmp_mode_ctrl #(
  parameter int NIRQ = 32,
  parameter int DEPTH = 5
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  output cmp_pkg::cmp_mem_req_s mem_o,
  input wire logic mem_ack,
  input wire logic [31:0] mem_rdata,
  input wire logic [NIRQ-1:0] irq_pend,
  input wire logic [2*NIRQ-1:0] irq_prio,
  input wire logic nmi_pend,
  input wire logic svc_exec,
  input wire logic [1:0] svc_prio,
  input wire logic exc_ret,
  input wire logic ldm_busy,
  input wire cmp_pkg::cmp_ctrl_wr_s ctrl_wr,
  input wire logic cps_req,
  input wire logic cps_mask,
  input wire logic spr_wr,
  input wire logic spr_psp,
  input wire logic [31:0] spr_data,
  input wire cmp_pkg::cmp_periph_acc_s periph_acc,
  input wire logic sw_push,
  input wire logic sw_pop,
  input wire logic [31:0] sw_wdata,
  input wire logic [31:0] ctx_wdata,
  output logic [2:0] ctx_idx,
  output logic ctx_restore,
  output logic [31:0] ctx_rdata,
  output logic sw_done,
  output logic [31:0] sw_rdata,
  output logic sw_busy,
  output logic periph_refuse,
  output logic privileged,
  output logic handler_mode,
  output logic sp_sel_psp,
  output logic [1:0] ctrl_value,
  output logic primask,
  output logic [5:0] exc_num,
  output logic exc_taken,
  output logic tail_chain,
  output logic exc_done,
  output logic ldm_abandon,
  output logic ldm_restart,
  output logic boot_done,
  output logic [31:0] start_pc,
  output logic exec_tbit,
  output logic [31:0] main_stack_pointer,
  output logic [31:0] process_stack_pointer,
  output logic [31:0] active_sp
);
  import cmp_pkg::*;

  cmp_state_e st_q;
  logic [1:0] ctrl_q;
  logic primask_q;
  logic [5:0] ipsr_q;
  logic [2:0] cur_rank_q;
  logic svc_pend_q;
  cmp_frame_s frames_q [DEPTH];
  logic [2:0] depth_q;
  cmp_frame_s ent_q;
  cmp_frame_s ret_q;
  logic [2:0] wcnt_q;
  logic phase_q;
  logic [31:0] sw_data_q;
  logic [31:0] ctx_rdata_q;
  logic ctx_restore_q;
  logic sw_done_q;
  logic exc_taken_q;
  logic tail_q;
  logic exc_done_q;
  logic abandon_q;
  logic restart_q;
  logic boot_done_q;
  logic [31:0] start_pc_q;
  logic tbit_q;
  logic handler;
  logic priv;
  logic sel_psp;
  logic sp_dec;
  logic sp_inc;
  logic [2:0] cand_rank;
  logic [5:0] cand_num;
  logic take;
  logic ret_now;
  logic chain;
  cmp_frame_s top;

  // NMI ranks above every programmable level; level p ranks p+1
  function automatic logic [2:0] rank_of(input logic [1:0] p);
    rank_of = {1'b0, p} + 3'h1;
  endfunction

  assign handler = (ipsr_q != `CMP_EXC_THREAD);
  assign priv = handler || !ctrl_q[`CMP_CTRL_NPRIV_BIT];
  assign top = (depth_q == 3'h0) ? '0 : frames_q[depth_q - 3'h1];

  // Stacking follows the interrupted context; unstacking follows the restored one
  always_comb begin
    if (st_q == CMP_ST_STACK) begin
      sel_psp = ent_q.process_stack_pointer;
    end else if (st_q == CMP_ST_UNSTACK) begin
      sel_psp = ret_q.process_stack_pointer;
    end else begin
      sel_psp = !handler && ctrl_q[`CMP_CTRL_SPSEL_BIT];
    end
  end

  // Highest rank wins; on a tie the lower exception number is kept
  always_comb begin
    cand_rank = `CMP_RANK_THREAD;
    cand_num = `CMP_EXC_THREAD;
    if (!primask_q) begin
      if (svc_pend_q) begin
        cand_rank = rank_of(svc_prio);
        cand_num = `CMP_EXC_SVC;
      end
      for (int i = 0; i < NIRQ; i++) begin
        if (irq_pend[i] && rank_of(irq_prio[2*i +: 2]) < cand_rank) begin
          cand_rank = rank_of(irq_prio[2*i +: 2]);
          cand_num = `CMP_EXC_IRQ0 + 6'(i);
        end
      end
    end
    if (nmi_pend) begin
      cand_rank = `CMP_RANK_NMI;
      cand_num = `CMP_EXC_NMI;
    end
  end

  assign ret_now = (st_q == CMP_ST_RUN) && exc_ret && handler;
  assign chain = ret_now && (cand_rank < top.rank);
  assign take = (st_q == CMP_ST_RUN) && !ret_now && (cand_rank < cur_rank_q);
  assign sp_dec = (st_q == CMP_ST_PUSH || st_q == CMP_ST_STACK) && !phase_q;
  assign sp_inc = (st_q == CMP_ST_POP || st_q == CMP_ST_UNSTACK) && mem_ack;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      st_q <= CMP_ST_BOOT_SP;
      wcnt_q <= 3'h0;
      phase_q <= 1'b0;
      ipsr_q <= `CMP_EXC_THREAD;
      cur_rank_q <= `CMP_RANK_THREAD;
      depth_q <= 3'h0;
      ent_q <= '0;
      ret_q <= '0;
      sw_data_q <= 32'h00000000;
    end else begin
      unique case (st_q)
        CMP_ST_BOOT_SP: if (mem_ack) st_q <= CMP_ST_BOOT_PC;
        CMP_ST_BOOT_PC: if (mem_ack) st_q <= CMP_ST_RUN;
        CMP_ST_RUN: begin
          if (chain) begin
            ipsr_q <= cand_num;
            cur_rank_q <= cand_rank;
          end else if (ret_now) begin
            ret_q <= top;
            depth_q <= depth_q - 3'h1;
            wcnt_q <= 3'h0;
            st_q <= CMP_ST_UNSTACK;
          end else if (take) begin
            ent_q <= '{rank: cand_rank, num: cand_num, process_stack_pointer: sel_psp, abandon: ldm_busy};
            frames_q[depth_q] <= '{rank: cur_rank_q, num: ipsr_q, process_stack_pointer: sel_psp,
                                   abandon: ldm_busy};
            depth_q <= depth_q + 3'h1;
            wcnt_q <= `CMP_FRAME_LAST;
            phase_q <= 1'b0;
            st_q <= CMP_ST_STACK;
          end else if (sw_push) begin
            sw_data_q <= sw_wdata;
            phase_q <= 1'b0;
            st_q <= CMP_ST_PUSH;
          end else if (sw_pop) begin
            st_q <= CMP_ST_POP;
          end
        end
        CMP_ST_PUSH: begin
          if (!phase_q) begin
            phase_q <= 1'b1;
          end else if (mem_ack) begin
            phase_q <= 1'b0;
            st_q <= CMP_ST_RUN;
          end
        end
        CMP_ST_POP: if (mem_ack) st_q <= CMP_ST_RUN;
        CMP_ST_STACK: begin
          if (!phase_q) begin
            phase_q <= 1'b1;
          end else if (mem_ack) begin
            phase_q <= 1'b0;
            wcnt_q <= wcnt_q - 3'h1;
            if (wcnt_q == 3'h0) begin
              ipsr_q <= ent_q.num;
              cur_rank_q <= ent_q.rank;
              st_q <= CMP_ST_RUN;
            end
          end
        end
        CMP_ST_UNSTACK: begin
          if (mem_ack) begin
            wcnt_q <= wcnt_q + 3'h1;
            if (wcnt_q == `CMP_FRAME_LAST) begin
              ipsr_q <= ret_q.num;
              cur_rank_q <= ret_q.rank;
              st_q <= CMP_ST_RUN;
            end
          end
        end
      endcase
    end
  end

  // Memory port: boot vectors, frame words and software push or pop
  always_comb begin
    mem_o = '0;
    unique case (st_q)
      CMP_ST_BOOT_SP: mem_o = '{req: 1'b1, we: 1'b0, addr: `CMP_VEC_SP_ADDR, wdata: '0};
      CMP_ST_BOOT_PC: mem_o = '{req: 1'b1, we: 1'b0, addr: `CMP_VEC_PC_ADDR, wdata: '0};
      CMP_ST_RUN: mem_o = '0;
      CMP_ST_PUSH: mem_o = '{req: phase_q, we: phase_q, addr: active_sp, wdata: sw_data_q};
      CMP_ST_STACK: mem_o = '{req: phase_q, we: phase_q, addr: active_sp, wdata: ctx_wdata};
      CMP_ST_POP, CMP_ST_UNSTACK: mem_o = '{req: 1'b1, we: 1'b0, addr: active_sp, wdata: '0};
    endcase
  end

  // Set wins over clear so a call in the entry cycle is not lost
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      svc_pend_q <= 1'b0;
    end else if (svc_exec) begin
      svc_pend_q <= 1'b1;
    end else if (take && cand_num == `CMP_EXC_SVC) begin
      svc_pend_q <= 1'b0;
    end else if (chain && cand_num == `CMP_EXC_SVC) begin
      svc_pend_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ctrl_q <= `CMP_CTRL_RESET;
    end else if (ctrl_wr.wr && priv) begin
      ctrl_q <= {ctrl_wr.spsel, ctrl_wr.npriv};
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      primask_q <= 1'b0;
    end else if (cps_req && priv) begin
      primask_q <= cps_mask;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      boot_done_q <= 1'b0;
      start_pc_q <= 32'h00000000;
      tbit_q <= 1'b0;
    end else begin
      boot_done_q <= (st_q == CMP_ST_BOOT_PC) && mem_ack;
      if (st_q == CMP_ST_BOOT_PC && mem_ack) begin
        start_pc_q <= mem_rdata;
        tbit_q <= mem_rdata[`CMP_TBIT_POS];
      end
    end
  end

  // Event pulses and restored words, all registered
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ctx_restore_q <= 1'b0;
      ctx_rdata_q <= 32'h00000000;
      sw_done_q <= 1'b0;
      exc_taken_q <= 1'b0;
      tail_q <= 1'b0;
      exc_done_q <= 1'b0;
      abandon_q <= 1'b0;
      restart_q <= 1'b0;
    end else begin
      ctx_restore_q <= (st_q == CMP_ST_UNSTACK) && mem_ack;
      if ((st_q == CMP_ST_UNSTACK || st_q == CMP_ST_POP) && mem_ack) begin
        ctx_rdata_q <= mem_rdata;
      end
      sw_done_q <= (st_q == CMP_ST_PUSH || st_q == CMP_ST_POP) && mem_ack;
      exc_taken_q <= chain || (st_q == CMP_ST_STACK && phase_q && mem_ack && wcnt_q == 3'h0);
      tail_q <= chain;
      exc_done_q <= (st_q == CMP_ST_UNSTACK) && mem_ack && (wcnt_q == `CMP_FRAME_LAST);
      abandon_q <= take && ldm_busy;
      restart_q <= (st_q == CMP_ST_UNSTACK) && mem_ack && (wcnt_q == `CMP_FRAME_LAST)
                   && ret_q.abandon;
    end
  end

  cmp_stack_unit u_stack (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .sel_psp(sel_psp),
    .sp_dec(sp_dec),
    .sp_inc(sp_inc),
    .msp_load((st_q == CMP_ST_BOOT_SP && mem_ack) ||
              (st_q == CMP_ST_RUN && spr_wr && priv && !spr_psp)),
    .msp_load_data((st_q == CMP_ST_BOOT_SP) ? mem_rdata : spr_data),
    .psp_load(st_q == CMP_ST_RUN && spr_wr && priv && spr_psp),
    .psp_load_data(spr_data),
    .main_stack_pointer(main_stack_pointer),
    .process_stack_pointer(process_stack_pointer),
    .active_sp(active_sp)
  );

  assign periph_refuse = periph_acc.valid && !priv &&
                         (periph_acc.region != CMP_RGN_OTHER);
  assign ctx_idx = wcnt_q;
  assign ctx_restore = ctx_restore_q;
  assign ctx_rdata = ctx_rdata_q;
  assign sw_done = sw_done_q;
  assign sw_rdata = ctx_rdata_q;
  assign sw_busy = (st_q != CMP_ST_RUN) || ret_now || take;
  assign privileged = priv;
  assign handler_mode = handler;
  assign sp_sel_psp = sel_psp;
  assign ctrl_value = ctrl_q;
  assign primask = primask_q;
  assign exc_num = ipsr_q;
  assign exc_taken = exc_taken_q;
  assign tail_chain = tail_q;
  assign exc_done = exc_done_q;
  assign ldm_abandon = abandon_q;
  assign ldm_restart = restart_q;
  assign boot_done = boot_done_q;
  assign start_pc = start_pc_q;
  assign exec_tbit = tbit_q;

  AST_BOOT_THREAD: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (st_q == CMP_ST_BOOT_SP || st_q == CMP_ST_BOOT_PC) |-> !handler_mode)
    else $error("core not in thread mode during boot");
  AST_CTRL_GUARD: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (ctrl_wr.wr && !privileged) |=> $stable(ctrl_value))
    else $error("unprivileged control write took effect");
  AST_HANDLER_WRITE: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (ctrl_wr.wr && handler_mode) |=> ctrl_value == $past({ctrl_wr.spsel, ctrl_wr.npriv}))
    else $error("privileged control write lost");
  AST_PUSH_ORDER: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (st_q == CMP_ST_PUSH && !phase_q) |=>
      mem_o.req && mem_o.we && mem_o.addr == $past(active_sp) - `CMP_WORD_BYTES)
    else $error("push did not write at decremented pointer");
  AST_FULL_DESC: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (st_q == CMP_ST_PUSH && phase_q && mem_ack) |=> active_sp == $past(mem_o.addr))
    else $error("pointer does not hold last pushed item");
  AST_HANDLER_MSP: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (handler_mode && st_q == CMP_ST_RUN) |-> !sp_sel_psp && active_sp == main_stack_pointer)
    else $error("handler not on main stack");
  AST_CPS_GUARD: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (cps_req && !privileged) |=> primask == $past(primask))
    else $error("unprivileged code changed interrupt mask");
  AST_VEC_SP: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (st_q == CMP_ST_BOOT_SP && mem_ack) |=>
      main_stack_pointer == {$past(mem_rdata[31:2]), 2'h0} && mem_o.addr == `CMP_VEC_PC_ADDR)
    else $error("main stack pointer not loaded from vector");
  AST_TBIT: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (st_q == CMP_ST_BOOT_PC && mem_ack) |=> boot_done && exec_tbit == $past(mem_rdata[0]))
    else $error("execution state bit not copied");
  AST_TAIL: assert property (@(posedge clk_sys) disable iff (!rst_n)
    chain |=> tail_chain && exc_taken && !mem_o.req && exc_num == $past(cand_num))
    else $error("tail chain did not go straight to next handler");
endmodule
`default_nettype wire

// file: cmp_map.svh
// Offsets, field positions and reset values for the mode, privilege and stack control
`ifndef CMP_MAP_SVH
`define CMP_MAP_SVH
`define CMP_CTRL_NPRIV_BIT 0
`define CMP_CTRL_SPSEL_BIT 1
`define CMP_CTRL_RESET 2'h0
`define CMP_VEC_SP_ADDR 32'h00000000
`define CMP_VEC_PC_ADDR 32'h00000004
`define CMP_WORD_BYTES 32'h00000004
`define CMP_TBIT_POS 0
`define CMP_FRAME_LAST 3'h7
`define CMP_EXC_THREAD 6'h00
`define CMP_EXC_NMI 6'h02
`define CMP_EXC_SVC 6'h0B
`define CMP_EXC_IRQ0 6'h10
`define CMP_RANK_NMI 3'h0
`define CMP_RANK_THREAD 3'h7
`define CMP_SP_RESET 32'h00000000
`endif

// file: cmp_pkg.sv
// Types shared by the mode, privilege and stack control
`default_nettype none
package cmp_pkg;
  typedef enum logic [2:0] {
    CMP_ST_BOOT_SP, CMP_ST_BOOT_PC, CMP_ST_RUN, CMP_ST_PUSH, CMP_ST_POP,
    CMP_ST_STACK, CMP_ST_UNSTACK
  } cmp_state_e;
  typedef enum logic [1:0] {
    CMP_RGN_OTHER, CMP_RGN_TIMER, CMP_RGN_IRQC, CMP_RGN_SCB
  } cmp_region_e;
  typedef struct packed {
    logic [2:0] rank;
    logic [5:0] num;
    logic process_stack_pointer;
    logic abandon;
  } cmp_frame_s;
  typedef struct packed {
    logic req;
    logic we;
    logic [31:0] addr;
    logic [31:0] wdata;
  } cmp_mem_req_s;
  typedef struct packed {
    logic wr;
    logic npriv;
    logic spsel;
  } cmp_ctrl_wr_s;
  typedef struct packed {
    logic valid;
    cmp_region_e region;
  } cmp_periph_acc_s;
endpackage
`default_nettype wire

// file: cmp_stack_unit.sv
// Main and process stack pointer pair with decrement and increment
`timescale 1ns/100ps
`default_nettype none
`include "cmp_map.svh"
module cmp_stack_unit (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic sel_psp,
  input wire logic sp_dec,
  input wire logic sp_inc,
  input wire logic msp_load,
  input wire logic [31:0] msp_load_data,
  input wire logic psp_load,
  input wire logic [31:0] psp_load_data,
  output logic [31:0] main_stack_pointer,
  output logic [31:0] process_stack_pointer,
  output logic [31:0] active_sp
);
  import cmp_pkg::*;
  logic [31:0] msp_q;
  logic [31:0] psp_q;

  // Low two bits stay zero so every frame word is aligned
  function automatic logic [31:0] align_word(input logic [31:0] v);
    align_word = {v[31:2], 2'h0};
  endfunction

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      msp_q <= `CMP_SP_RESET;
    end else if (msp_load) begin
      msp_q <= align_word(msp_load_data);
    end else if (!sel_psp && sp_dec) begin
      msp_q <= msp_q - `CMP_WORD_BYTES;
    end else if (!sel_psp && sp_inc) begin
      msp_q <= msp_q + `CMP_WORD_BYTES;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      psp_q <= `CMP_SP_RESET;
    end else if (psp_load) begin
      psp_q <= align_word(psp_load_data);
    end else if (sel_psp && sp_dec) begin
      psp_q <= psp_q - `CMP_WORD_BYTES;
    end else if (sel_psp && sp_inc) begin
      psp_q <= psp_q + `CMP_WORD_BYTES;
    end
  end

  assign main_stack_pointer = msp_q;
  assign process_stack_pointer = psp_q;
  assign active_sp = sel_psp ? psp_q : msp_q;
endmodule
`default_nettype wire

// file: cmp_mem_model.sv
// Memory model answering the core's request port, with fast or slow answers
`timescale 1ns/100ps
`default_nettype none
module cmp_mem_model (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic slow,
  input wire cmp_pkg::cmp_mem_req_s mem_o,
  output logic mem_ack,
  output logic [31:0] mem_rdata
);
  import cmp_pkg::*;
  logic [31:0] mem [0:511];
  logic [1:0] wait_q;
  initial begin
    for (int i = 0; i < 512; i++) begin
      mem[i] = 32'h00000000;
    end
    mem[0] = 32'h00000400;
    mem[1] = 32'h00000101;
    mem_ack = 1'b0;
    mem_rdata = 32'h5A5A5A5A;
    wait_q = 2'h0;
  end
  // Read data toggles outside the ack cycle so a stale sample never looks valid
  always @(posedge clk_sys) begin
    if (!rst_n || mem_ack) begin
      mem_ack <= 1'b0;
      wait_q <= 2'h0;
      mem_rdata <= ~mem_rdata;
    end else if (mem_o.req && (!slow || wait_q == 2'h3)) begin
      mem_ack <= 1'b1;
      mem_rdata <= mem[mem_o.addr[10:2]];
      if (mem_o.we) begin
        mem[mem_o.addr[10:2]] <= mem_o.wdata;
      end
    end else begin
      wait_q <= mem_o.req ? wait_q + 2'h1 : 2'h0;
      mem_rdata <= ~mem_rdata;
    end
  end
endmodule
`default_nettype wire

// file: cpu_mode_privilege_stack_ctrl_test.sv
// Self-checking bench for mode, privilege and stack control
`timescale 1ns/100ps
`default_nettype none
module cpu_mode_privilege_stack_ctrl_test;
  import cmp_pkg::*;
  logic clk_sys, rst_n, mem_ack, slow, nmi_pend, svc_exec, exc_ret, ldm_busy;
  logic cps_req, cps_mask, spr_wr, spr_psp, sw_push, sw_pop, ctx_restore, sw_done, sw_busy;
  logic periph_refuse, privileged, handler_mode, sp_sel_psp, primask, exc_taken, tail_chain;
  logic exc_done, ldm_abandon, ldm_restart, boot_done, exec_tbit;
  logic [1:0] svc_prio, ctrl_value;
  logic [2:0] ctx_idx;
  logic [5:0] exc_num;
  logic [31:0] mem_rdata, spr_data, sw_wdata, ctx_wdata, ctx_rdata, sw_rdata, start_pc;
  logic [31:0] main_stack_pointer, process_stack_pointer, active_sp, irq_pend;
  logic [63:0] irq_prio;
  cmp_mem_req_s mem_o;
  cmp_ctrl_wr_s ctrl_wr;
  cmp_periph_acc_s periph_acc;
  int err_count = 0;
  int cmp_count = 0;
  int ev [9] = '{default: 0};
  // Frame words carry their own index so misplaced stacking shows up
  assign ctx_wdata = {29'h14B4A000, ctx_idx};
  cmp_mem_model cmp_mem_model_i (.clk_sys(clk_sys), .rst_n(rst_n), .slow(slow),
    .mem_o(mem_o), .mem_ack(mem_ack), .mem_rdata(mem_rdata));
  cmp_mode_ctrl #(.NIRQ(32), .DEPTH(5)) cmp_mode_ctrl_i (.clk_sys(clk_sys), .rst_n(rst_n),
    .mem_o(mem_o), .mem_ack(mem_ack), .mem_rdata(mem_rdata), .irq_pend(irq_pend),
    .irq_prio(irq_prio), .nmi_pend(nmi_pend), .svc_exec(svc_exec), .svc_prio(svc_prio),
    .exc_ret(exc_ret), .ldm_busy(ldm_busy), .ctrl_wr(ctrl_wr), .cps_req(cps_req),
    .cps_mask(cps_mask), .spr_wr(spr_wr), .spr_psp(spr_psp), .spr_data(spr_data),
    .periph_acc(periph_acc), .sw_push(sw_push), .sw_pop(sw_pop), .sw_wdata(sw_wdata),
    .ctx_wdata(ctx_wdata), .ctx_idx(ctx_idx), .ctx_restore(ctx_restore),
    .ctx_rdata(ctx_rdata), .sw_done(sw_done), .sw_rdata(sw_rdata), .sw_busy(sw_busy),
    .periph_refuse(periph_refuse), .privileged(privileged), .handler_mode(handler_mode),
    .sp_sel_psp(sp_sel_psp), .ctrl_value(ctrl_value), .primask(primask),
    .exc_num(exc_num), .exc_taken(exc_taken), .tail_chain(tail_chain),
    .exc_done(exc_done), .ldm_abandon(ldm_abandon), .ldm_restart(ldm_restart),
    .boot_done(boot_done), .start_pc(start_pc), .exec_tbit(exec_tbit), .main_stack_pointer(main_stack_pointer),
    .process_stack_pointer(process_stack_pointer), .active_sp(active_sp));
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  // Pulse counters, so one-cycle outputs are never missed by the tests
  always @(posedge clk_sys) begin
    ev[0] += int'(exc_taken === 1'b1);
    ev[1] += int'(tail_chain === 1'b1);
    ev[2] += int'(exc_done === 1'b1);
    ev[3] += int'(ldm_abandon === 1'b1);
    ev[4] += int'(ldm_restart === 1'b1);
    ev[5] += int'(mem_ack === 1'b1);
    ev[6] += int'(sw_done === 1'b1);
    ev[7] += int'(ctx_restore === 1'b1);
    ev[8] += int'(boot_done === 1'b1);
  end
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wait_ev(input int k, input int n);
    int i;
    i = 0;
    while (ev[k] < n && i < 300) begin
      @(negedge clk_sys);
      i++;
    end
    check("event count", ev[k], n);
  endtask
  task automatic t_boot();
    wait_ev(8, 1);
    check("msp", main_stack_pointer, 32'h00000400);
    check("tbit", exec_tbit, 1'b1);
    check("pc", start_pc, 32'h00000101);
    check("handler", handler_mode, 1'b0);
    check("priv", privileged, 1'b1);
    check("ctrl", ctrl_value, 2'h0);
    check("sel", sp_sel_psp, 1'b0);
    $display("done boot");
  endtask
  task automatic t_push_pop();
    @(negedge clk_sys);
    check("busy", sw_busy, 1'b0);
    sw_wdata = 32'h12345678;
    sw_push = 1'b1;
    @(negedge clk_sys);
    sw_push = 1'b0;
    wait_ev(6, 1);
    check("msp push", main_stack_pointer, 32'h000003FC);
    check("mem top", cmp_mem_model_i.mem[255], 32'h12345678);
    sw_pop = 1'b1;
    @(negedge clk_sys);
    sw_pop = 1'b0;
    wait_ev(6, 2);
    check("pop data", sw_rdata, 32'h12345678);
    check("msp pop", main_stack_pointer, 32'h00000400);
    $display("done push_pop");
  endtask
  task automatic t_ctrl();
    spr_psp = 1'b1;
    spr_data = 32'h00000300;
    spr_wr = 1'b1;
    @(negedge clk_sys);
    spr_wr = 1'b0;
    check("psp", process_stack_pointer, 32'h00000300);
    check("msp kept", main_stack_pointer, 32'h00000400);
    ctrl_wr = '{1'b1, 1'b0, 1'b1};
    @(negedge clk_sys);
    check("psp sel", active_sp, 32'h00000300);
    check("ctrl", ctrl_value, 2'h2);
    ctrl_wr = '{1'b1, 1'b1, 1'b1};
    @(negedge clk_sys);
    check("unpriv", privileged, 1'b0);
    ctrl_wr = '{1'b1, 1'b0, 1'b0};
    @(negedge clk_sys);
    ctrl_wr = '0;
    check("ctrl kept", ctrl_value, 2'h3);
    cps_mask = 1'b1;
    cps_req = 1'b1;
    @(negedge clk_sys);
    cps_req = 1'b0;
    check("mask", primask, 1'b0);
    for (int r = 0; r < 4; r++) begin
      periph_acc = '{1'b1, cmp_region_e'(2'(r))};
      @(negedge clk_sys);
      check("refuse", periph_refuse, r != 0);
    end
    periph_acc = '0;
    $display("done ctrl");
  endtask
  task automatic t_svc();
    svc_prio = 2'h2;
    svc_exec = 1'b1;
    @(negedge clk_sys);
    svc_exec = 1'b0;
    wait_ev(0, 1);
    check("svc num", exc_num, 6'h0B);
    check("handler", handler_mode, 1'b1);
    check("h priv", privileged, 1'b1);
    check("h sp", active_sp, 32'h00000400);
    check("psp frame", process_stack_pointer, 32'h000002E0);
    check("word7", cmp_mem_model_i.mem[191], 32'hA5A50007);
    check("word0", cmp_mem_model_i.mem[184], 32'hA5A50000);
    periph_acc = '{1'b1, CMP_RGN_SCB};
    @(negedge clk_sys);
    check("h refuse", periph_refuse, 1'b0);
    periph_acc = '0;
    ctrl_wr = '{1'b1, 1'b0, 1'b0};
    @(negedge clk_sys);
    check("h ctrl", ctrl_value, 2'h0);
    ctrl_wr = '{1'b1, 1'b1, 1'b1};
    @(negedge clk_sys);
    ctrl_wr = '0;
    check("h ctrl back", ctrl_value, 2'h3);
    check("h sel", sp_sel_psp, 1'b0);
    cps_req = 1'b1;
    @(negedge clk_sys);
    check("h mask", primask, 1'b1);
    cps_mask = 1'b0;
    @(negedge clk_sys);
    cps_req = 1'b0;
    check("h unmask", primask, 1'b0);
    $display("done svc");
  endtask
  task automatic t_tail();
    int m;
    irq_prio[7:6] = 2'h3;
    irq_pend[3] = 1'b1;
    repeat (4) @(negedge clk_sys);
    check("no preempt", ev[0], 1);
    m = ev[5];
    exc_ret = 1'b1;
    @(negedge clk_sys);
    exc_ret = 1'b0;
    wait_ev(1, 1);
    irq_pend = '0;
    check("chain num", exc_num, 6'h13);
    check("no memory", ev[5], m);
    exc_ret = 1'b1;
    @(negedge clk_sys);
    exc_ret = 1'b0;
    wait_ev(2, 1);
    check("thread", handler_mode, 1'b0);
    check("restores", ev[7], 8);
    check("last restore", ctx_rdata, 32'hA5A50007);
    check("psp back", process_stack_pointer, 32'h00000300);
    check("unpriv back", privileged, 1'b0);
    check("psp active", active_sp, 32'h00000300);
    $display("done tail");
  endtask
  task automatic t_nest();
    slow = 1'b1;
    ldm_busy = 1'b1;
    irq_prio[11:8] = 4'h6;
    irq_pend[5:4] = 2'h3;
    wait_ev(3, 1);
    ldm_busy = 1'b0;
    wait_ev(0, 3);
    irq_pend = '0;
    check("best irq", exc_num, 6'h15);
    nmi_pend = 1'b1;
    wait_ev(0, 4);
    nmi_pend = 1'b0;
    check("nmi", exc_num, 6'h02);
    check("nest msp", main_stack_pointer, 32'h000003E0);
    exc_ret = 1'b1;
    @(negedge clk_sys);
    exc_ret = 1'b0;
    wait_ev(2, 2);
    check("back irq", exc_num, 6'h15);
    check("still handler", handler_mode, 1'b1);
    check("no restart yet", ev[4], 0);
    exc_ret = 1'b1;
    @(negedge clk_sys);
    exc_ret = 1'b0;
    wait_ev(2, 3);
    wait_ev(4, 1);
    check("thread", handler_mode, 1'b0);
    slow = 1'b0;
    $display("done nest");
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    rst_n = 1'b0;
    {slow, nmi_pend, svc_exec, exc_ret, ldm_busy, cps_req, cps_mask} = '0;
    {spr_wr, spr_psp, sw_push, sw_pop, svc_prio} = '0;
    {spr_data, sw_wdata, irq_pend, irq_prio} = '0;
    ctrl_wr = '0;
    periph_acc = '0;
    repeat (8) @(negedge clk_sys);
    rst_n = 1'b1;
    t_boot();
    t_push_pop();
    t_ctrl();
    t_svc();
    t_tail();
    t_nest();
    tally_and_finish();
  end
  // Whole run needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clk_sys);
    err_count++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
